/* File: hw/tbpwm_pkg.sv */
// package for the timer based pwm unit: register map, fields, reset values
// Behaviour
// - pwm mode drives pin, 10-bit duty
// - control written zero clears output latch
// - period is (limit+1)*4*prescale oscillator periods
// - counter clears after matching period limit
// - boundary sets pin unless duty zero
// - boundary copies duty into shadow and latch
// - duty byte is msbs, control 5:4 lsbs
// - high time is duty*osc*prescale
// - duty writes take effect next boundary
// - shadow register is read-only in pwm
// - shadow plus 2-bit latch double buffer
// - pin clears when shadow matches extended counter
// - duty beyond period keeps pin high
// - prescale factors 1, 4, 16
// - auto-shutdown only on unit one
// - mode 0000 turns unit off, resets
package tbpwm_pkg;
  localparam logic [11:0] OFS_COUNT = 12'h000;
  localparam logic [11:0] OFS_PERIOD = 12'h004;
  localparam logic [11:0] OFS_TBCTL = 12'h008;
  localparam logic [11:0] OFS_U1_LOW = 12'h00C;
  localparam logic [11:0] OFS_U1_SHADOW = 12'h010;
  localparam logic [11:0] OFS_U1_CTL = 12'h014;
  localparam logic [11:0] OFS_U2_LOW = 12'h018;
  localparam logic [11:0] OFS_U2_SHADOW = 12'h01C;
  localparam logic [11:0] OFS_U2_CTL = 12'h020;
  localparam logic [11:0] OFS_SHUTDOWN = 12'h024;
  localparam logic [11:0] OFS_DEADBAND = 12'h028;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam int TB_ON_BIT = 2;
  localparam int SHUT_EN_BIT = 7;
  localparam logic [7:0] TBCTL_MASK = 8'h7F;
  localparam logic [7:0] U2CTL_MASK = 8'h3F;
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV16A = 2'h2;
  localparam logic [1:0] PRE_DIV16B = 2'h3;
  localparam logic [1:0] PWM_MODE_TOP = 2'h3;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] PRE_LAST1 = 4'h0;
  localparam logic [3:0] PRE_LAST4 = 4'h3;
  localparam logic [3:0] PRE_LAST16 = 4'hF;
  localparam logic [3:0] MODE_OFF = 4'h0;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] shadow;
    logic [1:0] latch;
    logic out;
  } tbpwm_unit_t;
endpackage : tbpwm_pkg

/* File: hw/tbpwm_top.sv */
// timer based pwm unit: timebase, two pwm channels, apb registers
`timescale 1ns/1ps
`default_nettype none
module tbpwm_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shutdown request pin for unit one
  input wire logic shutdown_in,
  // pwm pins
  output logic pwm_output_pin_one,
  output logic pwm_output_pin_two
);
  logic [7:0] timebase_count, period_limit, timebase_control;
  logic [7:0] unit1_control, unit2_control, auto_shutdown_control, dead_band_restart_control;
  tbpwm_pkg::tbpwm_unit_t u1, u2;
  logic [3:0] prescale_count;
  logic [1:0] phase;
  logic sd_meta, sd_sync, shutdown_active;

  wire wr = psel && penable && pwrite;
  wire hit_count = paddr == tbpwm_pkg::OFS_COUNT;
  wire hit_period = paddr == tbpwm_pkg::OFS_PERIOD;
  wire hit_tbctl = paddr == tbpwm_pkg::OFS_TBCTL;
  wire hit_u1low = paddr == tbpwm_pkg::OFS_U1_LOW;
  wire hit_u1sh = paddr == tbpwm_pkg::OFS_U1_SHADOW;
  wire hit_u1ctl = paddr == tbpwm_pkg::OFS_U1_CTL;
  wire hit_u2low = paddr == tbpwm_pkg::OFS_U2_LOW;
  wire hit_u2sh = paddr == tbpwm_pkg::OFS_U2_SHADOW;
  wire hit_u2ctl = paddr == tbpwm_pkg::OFS_U2_CTL;
  wire hit_sd = paddr == tbpwm_pkg::OFS_SHUTDOWN;
  wire hit_db = paddr == tbpwm_pkg::OFS_DEADBAND;
  wire mapped = hit_count | hit_period | hit_tbctl | hit_u1low | hit_u1sh | hit_u1ctl
              | hit_u2low | hit_u2sh | hit_u2ctl | hit_sd | hit_db;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // prescaler: quarter-cycle phase plus prescale terminal count
  wire [1:0] presel = timebase_control[1:0];
  wire tb_on = timebase_control[tbpwm_pkg::TB_ON_BIT];
  wire [3:0] pre_max = (presel == tbpwm_pkg::PRE_DIV1) ? tbpwm_pkg::PRE_LAST1 :
                       (presel == tbpwm_pkg::PRE_DIV4) ? tbpwm_pkg::PRE_LAST4 : tbpwm_pkg::PRE_LAST16;
  // one timebase increment every 4 * prescale clocks
  wire tick = tb_on && phase == tbpwm_pkg::PHASE_LAST && prescale_count == pre_max;
  wire boundary = tick && timebase_count == period_limit;
  // 2 low-order bits below the counter: phase for 1:1, prescaler bits otherwise
  wire [1:0] fine = (presel == tbpwm_pkg::PRE_DIV1) ? phase :
                    (presel == tbpwm_pkg::PRE_DIV4) ? prescale_count[1:0] : prescale_count[3:2];
  wire [9:0] fine_count = {timebase_count, fine};
  // compare against the value the fine count takes at this edge: the pin is a flop,
  // so matching the current value would stretch every pulse by one clock
  wire fine_step = tb_on && (presel == tbpwm_pkg::PRE_DIV1 || (phase == tbpwm_pkg::PHASE_LAST
                   && (presel == tbpwm_pkg::PRE_DIV4 || prescale_count[1:0] == tbpwm_pkg::PHASE_LAST)));
  wire [9:0] fine_next = fine_count + 10'h001;

  function automatic logic is_pwm(input logic [7:0] ctl);
    is_pwm = ctl[3:2] == tbpwm_pkg::PWM_MODE_TOP;
  endfunction : is_pwm

  function automatic tbpwm_pkg::tbpwm_unit_t step_unit(input tbpwm_pkg::tbpwm_unit_t u,
      input logic [7:0] ctl, input logic [9:0] fc, input logic stp, input logic bnd, input logic kill);
    tbpwm_pkg::tbpwm_unit_t n;
    logic [9:0] duty;
    n = u;
    duty = {u.low, ctl[5:4]};
    if (ctl[3:0] == tbpwm_pkg::MODE_OFF) begin
      n.out = 1'b0;
      n.shadow = tbpwm_pkg::RST_BYTE;
      n.latch = 2'h0;
    end else if (!is_pwm(ctl) || kill) begin
      n.out = 1'b0;
    end else if (bnd) begin
      n.shadow = duty[9:2];
      n.latch = duty[1:0];
      n.out = duty != 10'h000;
    end else if (stp && {u.shadow, u.latch} == fc) begin
      n.out = 1'b0;
    end
    return n;
  endfunction : step_unit

  wire [7:0] wbyte = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      prescale_count <= 4'h0;
    end else if (!tb_on) begin
      phase <= phase;
    end else begin
      phase <= phase + 2'h1;
      if (phase == tbpwm_pkg::PHASE_LAST) begin
        prescale_count <= (prescale_count == pre_max) ? 4'h0 : prescale_count + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_count <= tbpwm_pkg::RST_BYTE;
    end else if (wr && hit_count) begin
      timebase_count <= wbyte;
    end else if (boundary) begin
      timebase_count <= 8'h00;
    end else if (tick) begin
      timebase_count <= timebase_count + 8'h01;
    end
  end

  // shutdown pin synchroniser; unit two has no shutdown path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_meta <= 1'b0;
      sd_sync <= 1'b0;
    end else begin
      sd_meta <= shutdown_in;
      sd_sync <= sd_meta;
    end
  end
  assign shutdown_active = auto_shutdown_control[tbpwm_pkg::SHUT_EN_BIT] && sd_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_limit <= tbpwm_pkg::RST_PERIOD;
      timebase_control <= tbpwm_pkg::RST_BYTE;
      unit1_control <= tbpwm_pkg::RST_BYTE;
      unit2_control <= tbpwm_pkg::RST_BYTE;
      auto_shutdown_control <= tbpwm_pkg::RST_BYTE;
      dead_band_restart_control <= tbpwm_pkg::RST_BYTE;
    end else if (wr) begin
      if (hit_period) period_limit <= wbyte;
      if (hit_tbctl) timebase_control <= wbyte & tbpwm_pkg::TBCTL_MASK;
      if (hit_u1ctl) unit1_control <= wbyte;
      if (hit_u2ctl) unit2_control <= wbyte & tbpwm_pkg::U2CTL_MASK;
      if (hit_sd) auto_shutdown_control <= wbyte;
      if (hit_db) dead_band_restart_control <= wbyte;
    end
  end

  // unit state: duty low byte is software's, shadow and latch are hardware's
  tbpwm_pkg::tbpwm_unit_t n1, n2;
  assign n1 = step_unit(u1, unit1_control, fine_next, fine_step, boundary, shutdown_active);
  assign n2 = step_unit(u2, unit2_control, fine_next, fine_step, boundary, 1'b0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u1 <= '0;
      u2 <= '0;
    end else begin
      u1 <= n1;
      u2 <= n2;
      // writes to the shadow are dropped: it is read-only in pwm
      if (wr && hit_u1low) u1.low <= wbyte;
      if (wr && hit_u2low) u2.low <= wbyte;
    end
  end

  assign pwm_output_pin_one = u1.out;
  assign pwm_output_pin_two = u2.out;

  wire [7:0] rbyte = hit_count ? timebase_count :
                     hit_period ? period_limit :
                     hit_tbctl ? timebase_control :
                     hit_u1low ? u1.low :
                     hit_u1sh ? u1.shadow :
                     hit_u1ctl ? unit1_control :
                     hit_u2low ? u2.low :
                     hit_u2sh ? u2.shadow :
                     hit_u2ctl ? unit2_control :
                     hit_sd ? auto_shutdown_control :
                     hit_db ? dead_band_restart_control : 8'h00;
  assign prdata = {24'h000000, rbyte};
endmodule : tbpwm_top
`default_nettype wire

/* File: dv/tbpwm_assertions.sv */
// assertion checker for the timer based pwm unit
`timescale 1ns/1ps
`default_nettype none
module tbpwm_chk (
  // apb and pin
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_output_pin_one,
  // shutdown request and second pin
  input wire logic shutdown_in,
  input wire logic pwm_output_pin_two
);
  logic [3:0] m1, m2;
  logic sd_en;
  wire acc = psel && penable;
  // anything past the last register or off a word boundary is unmapped
  wire bad = paddr > tbpwm_pkg::OFS_DEADBAND || paddr[1:0] != 2'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mode copy taken from the bus, so no internal probe is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m1 <= 4'h0;
      m2 <= 4'h0;
      sd_en <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == tbpwm_pkg::OFS_U1_CTL) m1 <= pwdata[3:0];
      if (paddr == tbpwm_pkg::OFS_U2_CTL) m2 <= pwdata[3:0];
      if (paddr == tbpwm_pkg::OFS_SHUTDOWN) sd_en <= pwdata[tbpwm_pkg::SHUT_EN_BIT];
    end
  end
  a_ready_high: assert property (pready) else $error("not ready");
  a_unmapped_err: assert property (acc && bad |-> pslverr) else $error("no slverr");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr) else $error("slverr");
  a_idle_quiet: assert property (!acc |-> !pslverr) else $error("idle slverr");
  a_unmapped_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0) else $error("read");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper");
  a_unit2_top: assert property (acc && !pwrite && paddr == tbpwm_pkg::OFS_U2_CTL |-> prdata[7:6] == 2'h0)
    else $error("unit two bits");
  a_pin_off: assert property (m1[3:2] != 2'h3 |=> !pwm_output_pin_one) else $error("pin one");
  a_pin_two_off: assert property (m2[3:2] != 2'h3 |=> !pwm_output_pin_two) else $error("pin two");
  // two synchroniser flops, then the pin flop
  a_shutdown_low: assert property (sd_en && $past(shutdown_in) && $past(shutdown_in, 2) |=> !pwm_output_pin_one)
    else $error("shutdown pin");
  c_rise: cover property ($rose(pwm_output_pin_one));
  c_error: cover property (acc && pslverr);
  c_pwm: cover property (m1 == 4'hC);
  c_shutdown: cover property (sd_en && shutdown_in && pwm_output_pin_two);
endmodule : tbpwm_chk
bind tbpwm_top tbpwm_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_output_pin_one(pwm_output_pin_one),
  .shutdown_in(shutdown_in), .pwm_output_pin_two(pwm_output_pin_two)
);
`default_nettype wire

/* File: dv/tbpwm_bench.sv */
// self-checking bench for the timer based pwm unit
`timescale 1ns/1ps
`default_nettype none
module tbpwm_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, shutdown_in = 1'b0;
  logic pready, pslverr, pin1, pin2, p1d;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, e;
  logic [31:0] rq[$], hq[$], pq[$];
  int fail_count = 0, samples_checked = 0, cyc = 0, hi = 0, per = 0, p, d, pre;
  always #50 pclk = ~pclk;
  tbpwm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_in(shutdown_in), .pwm_output_pin_one(pin1), .pwm_output_pin_two(pin2));
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) fail_count++;
    if (s !== x) $display("CHECK FAILED at %0t seen %h expected %h", $time, s, x);
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // for a read, v is the value expected back
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    if (!w) rq.push_back(v);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask : bus
  task automatic hold(input logic [1:0] x);
    repeat (8) begin
      repeat (64) @(negedge pclk);
      check({pin2, pin1}, x);
    end
  endtask : hold
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    p1d <= pin1;
    hi <= pin1 ? hi + 1 : 0;
    per <= (pin1 && !p1d) ? 1 : per + 1;
    if (psel && penable && pready && !pwrite) check(prdata, rq.pop_front());
    // high time counted in clocks, exactly duty times prescale
    if (!pin1 && p1d && hq.size() > 0) e = hq.pop_front();
    if (!pin1 && p1d && e !== 32'h0) check(hi, e);
    if (!pin1 && p1d) e = 32'h0;
    if (pin1 && !p1d && pq.size() > 0) check(per, pq.pop_front());
    if (cyc == 30000) fail_count++;
    if (cyc == 30000) print_verdict();
  end
  initial begin
    e = 32'h0;
    p = $urandom(45);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 12; i++) bus(1'b0, 12'(i * 4), {24'h0, i == 1 ? tbpwm_pkg::RST_PERIOD : tbpwm_pkg::RST_BYTE});
    bus(1'b1, tbpwm_pkg::OFS_U1_SHADOW, 32'hA5);
    bus(1'b0, tbpwm_pkg::OFS_U1_SHADOW, 32'h0);
    $display("register test done");
    for (int k = 0; k < 3; k++) begin
      pre = 1 << (2 * k);
      p = 2 + $urandom % 3;
      d = 4 + $urandom % (4 * p - 4);
      bus(1'b1, tbpwm_pkg::OFS_TBCTL, 32'h0);
      bus(1'b1, tbpwm_pkg::OFS_COUNT, 32'h0);
      bus(1'b1, tbpwm_pkg::OFS_PERIOD, p);
      bus(1'b1, tbpwm_pkg::OFS_U1_LOW, d >> 2);
      bus(1'b1, tbpwm_pkg::OFS_TBCTL, 4 + k);
      bus(1'b1, tbpwm_pkg::OFS_U1_CTL, (d % 4) * 16 + 12);
      @(posedge pin1);
      repeat (2) @(negedge pclk);
      hq.push_back(d * pre);
      pq.push_back((p + 1) * 4 * pre);
      repeat (12 * (p + 1) * pre) @(posedge pclk);
      $display("pwm test done, prescale %0d", pre);
    end
    @(posedge pin1);
    bus(1'b1, tbpwm_pkg::OFS_U1_LOW, 32'h0);
    bus(1'b0, tbpwm_pkg::OFS_U1_SHADOW, d >> 2);
    bus(1'b1, tbpwm_pkg::OFS_U1_CTL, 32'h0C);
    repeat (8 * (p + 1) * pre) @(posedge pclk);
    bus(1'b0, tbpwm_pkg::OFS_U1_SHADOW, 32'h0);
    hold(2'h0);
    bus(1'b1, tbpwm_pkg::OFS_U1_LOW, p + 1);
    bus(1'b1, tbpwm_pkg::OFS_U2_LOW, p + 1);
    bus(1'b1, tbpwm_pkg::OFS_U2_CTL, 32'h0C);
    repeat (8 * (p + 1) * pre) @(posedge pclk);
    hold(2'h3);
    bus(1'b1, tbpwm_pkg::OFS_SHUTDOWN, 32'h80);
    shutdown_in <= 1'b1;
    hold(2'h2);
    shutdown_in <= 1'b0;
    repeat (8 * (p + 1) * pre) @(posedge pclk);
    hold(2'h3);
    bus(1'b1, tbpwm_pkg::OFS_U1_CTL, 32'h0);
    bus(1'b0, tbpwm_pkg::OFS_U1_SHADOW, 32'h0);
    hold(2'h2);
    bus(1'b1, tbpwm_pkg::OFS_U1_CTL, 32'h8);
    repeat (8 * (p + 1) * pre) @(posedge pclk);
    hold(2'h2);
    $display("buffer and limit tests done");
    print_verdict();
  end
endmodule : tbpwm_bench
`default_nettype wire
